// ### rtl/mcsc_clk_mux.sv
// glitch-free source multiplexer for sampled oscillator levels
`timescale 1ns/100ps
`default_nettype none
module mcsc_clk_mux (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [2:0] src_lvl_i,
	input wire mcsc_pkg::mcsc_src_t sel_i,
	output logic clk_o,
	output mcsc_pkg::mcsc_src_t cur_sel_o,
	output logic busy_o
);
	mcsc_pkg::mcsc_mux_st_t state_r;
	mcsc_pkg::mcsc_src_t cur_r;
	mcsc_pkg::mcsc_src_t tgt_r;
	logic out_r;

	// old source is let finish its high phase, then the new one is joined
	// only while low, so every pulse out is a whole pulse of one source
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_r <= mcsc_pkg::MUX_RUN;
			cur_r <= mcsc_pkg::SRC_RING;
			tgt_r <= mcsc_pkg::SRC_RING;
			out_r <= 1'b0;
		end else begin
			case (state_r)
				mcsc_pkg::MUX_RUN: begin
					out_r <= src_lvl_i[cur_r];
					if (sel_i != cur_r) begin
						tgt_r <= sel_i;
						state_r <= mcsc_pkg::MUX_DRAIN;
					end
				end
				mcsc_pkg::MUX_DRAIN: begin
					out_r <= src_lvl_i[cur_r];
					// target follows late reselects, so a source stopped
					// after it was deselected is never joined
					tgt_r <= sel_i;
					if (!src_lvl_i[cur_r]) begin
						state_r <= mcsc_pkg::MUX_ARM;
					end
				end
				mcsc_pkg::MUX_ARM: begin
					out_r <= 1'b0;
					tgt_r <= sel_i;
					if (!src_lvl_i[tgt_r]) begin
						cur_r <= tgt_r;
						state_r <= mcsc_pkg::MUX_RUN;
					end
				end
				default: begin
					state_r <= mcsc_pkg::MUX_RUN;
				end
			endcase
		end
	end

	assign clk_o = out_r;
	assign cur_sel_o = cur_r;
	assign busy_o = (state_r != mcsc_pkg::MUX_RUN);

	chk_mux_switch_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$changed(cur_r) |-> !$past(out_r) && !out_r)
		else $error("source switched while output high");
	chk_mux_arm_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(state_r) == mcsc_pkg::MUX_ARM |-> !out_r)
		else $error("output not parked low between sources");
	cov_mux_switch: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		state_r == mcsc_pkg::MUX_ARM ##1 state_r == mcsc_pkg::MUX_RUN);
endmodule
`default_nettype wire

// ### rtl/mcsc_top.sv
// clock source control: apb registers, source mux, divider, port sharing
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module mcsc_top #(
	parameter int DIV_W = 3
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ring_osc_i,
	input wire logic main_clock_in_pin_i,
	input wire logic shared_port_bit_low_i,
	output logic shared_port_bit_low_o,
	output logic shared_port_bit_low_oe_n_o,
	input wire logic sub_clock_out_pin_i,
	output logic sub_clock_out_pin_o,
	output logic sub_clock_out_pin_oe_n_o,
	output logic ring_osc_en_o,
	output logic main_osc_en_o,
	output logic main_rc_mode_o,
	output logic sub_osc_en_o,
	output logic sys_clk_o,
	output logic instr_clk_o,
	output logic power_down_o,
	output logic deep_power_down_o
);
	logic [1:0] mode_div_r;
	mcsc_pkg::mcsc_src_t mode_sel_r;
	logic [2:0] stop_r;
	logic [3:0] port_r;
	logic rc_mode_r;
	logic pd_r;
	logic dpd_r;
	logic mux_prev_r;
	logic [DIV_W-1:0] div_cnt_r;
	logic sys_clk_r;
	logic sys_prev_r;
	logic [1:0] instr_cnt_r;
	logic instr_clk_r;
	logic [31:0] prdata_r;
	logic wr_en;
	logic rd_en;
	logic hit;
	logic mux_clk;
	logic mux_rise;
	logic mux_busy;
	logic [2:0] src_lvl;
	logic [2:0] stop_wr;
	logic [1:0] sel_wr;
	mcsc_pkg::mcsc_src_t mux_cur;

	// apb: zero wait states, error on unmapped address
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign hit = (paddr == mcsc_pkg::MODE_OFS) ||
		(paddr == mcsc_pkg::STOP_OFS) ||
		(paddr == mcsc_pkg::CMD_OFS) ||
		(paddr == mcsc_pkg::PORT_OFS) ||
		(paddr == mcsc_pkg::STAT_OFS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = prdata_r;

	assign sel_wr = pwdata[mcsc_pkg::MODE_SEL_LSB +: 2];
	// running oscillator keeps running: the requested and the still active
	// source are both protected while a switch is in flight
	always_comb begin
		stop_wr = pwdata[2:0];
		stop_wr[mode_sel_r] = 1'b0;
		stop_wr[mux_cur] = 1'b0;
	end

	// clock mode register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mode_div_r <= mcsc_pkg::MODE_RST[mcsc_pkg::MODE_DIV_LSB +: 2];
			mode_sel_r <= mcsc_pkg::SRC_RING;
		end else if (wr_en && paddr == mcsc_pkg::MODE_OFS) begin
			mode_div_r <= pwdata[mcsc_pkg::MODE_DIV_LSB +: 2];
			// 11 and stopped sources are refused, old selection kept
			if (sel_wr != 2'b11 && !stop_r[sel_wr]) begin
				mode_sel_r <= mcsc_pkg::mcsc_src_t'(sel_wr);
			end
		end
	end

	// oscillator stop register, write only
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			stop_r <= mcsc_pkg::STOP_RST;
		end else if (wr_en && paddr == mcsc_pkg::STOP_OFS) begin
			stop_r <= stop_wr;
		end
	end

	// one-shot rc select; no way back to ceramic short of reset
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rc_mode_r <= 1'b0;
		end else if (wr_en && paddr == mcsc_pkg::CMD_OFS &&
			pwdata[mcsc_pkg::CMD_RC_BIT]) begin
			rc_mode_r <= 1'b1;
		end
	end

	// power down requests are one-cycle pulses to the core; the block cannot
	// tell an external clock from a resonator, so that is left to software
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pd_r <= 1'b0;
			dpd_r <= 1'b0;
		end else begin
			pd_r <= wr_en && paddr == mcsc_pkg::CMD_OFS &&
				pwdata[mcsc_pkg::CMD_PD_BIT];
			dpd_r <= wr_en && paddr == mcsc_pkg::CMD_OFS &&
				pwdata[mcsc_pkg::CMD_DPD_BIT];
		end
	end

	// port data and direction for the shared pins
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			port_r <= mcsc_pkg::PORT_RST;
		end else if (wr_en && paddr == mcsc_pkg::PORT_OFS) begin
			port_r <= pwdata[3:0];
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_r <= 32'h00000000;
		end else if (rd_en) begin
			if (paddr == mcsc_pkg::MODE_OFS) begin
				prdata_r <= {28'h0000000, mode_div_r, mode_sel_r};
			end else if (paddr == mcsc_pkg::PORT_OFS) begin
				prdata_r <= {26'h0000000, sub_clock_out_pin_i,
					shared_port_bit_low_i, port_r};
			end else if (paddr == mcsc_pkg::STAT_OFS) begin
				prdata_r <= {28'h0000000, rc_mode_r, mux_busy, mux_cur};
			end else begin
				prdata_r <= 32'h00000000;
			end
		end
	end

	// sub-clock pins or port bits
	always_comb begin
		if (stop_r[mcsc_pkg::STOP_SUB_BIT]) begin
			shared_port_bit_low_o = port_r[0];
			shared_port_bit_low_oe_n_o = !port_r[mcsc_pkg::PORT_DIR_LSB];
			sub_clock_out_pin_o = port_r[1];
			sub_clock_out_pin_oe_n_o = !port_r[mcsc_pkg::PORT_DIR_LSB + 1];
		end else begin
			// crystal amplifier: drive the inverse of the input back out
			shared_port_bit_low_o = 1'b0;
			shared_port_bit_low_oe_n_o = 1'b1;
			sub_clock_out_pin_o = !shared_port_bit_low_i;
			sub_clock_out_pin_oe_n_o = 1'b0;
		end
	end

	assign ring_osc_en_o = !stop_r[mcsc_pkg::STOP_RING_BIT];
	assign main_osc_en_o = !stop_r[mcsc_pkg::STOP_MAIN_BIT];
	assign sub_osc_en_o = !stop_r[mcsc_pkg::STOP_SUB_BIT];
	assign main_rc_mode_o = rc_mode_r;
	assign power_down_o = pd_r;
	assign deep_power_down_o = dpd_r;

	// stopped oscillators present a flat low level to the mux
	assign src_lvl[0] = ring_osc_i && ring_osc_en_o;
	assign src_lvl[1] = main_clock_in_pin_i && main_osc_en_o;
	assign src_lvl[2] = shared_port_bit_low_i && sub_osc_en_o;

	mcsc_clk_mux u_mux (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.src_lvl_i(src_lvl),
		.sel_i(mode_sel_r),
		.clk_o(mux_clk),
		.cur_sel_o(mux_cur),
		.busy_o(mux_busy)
	);

	assign mux_rise = mux_clk && !mux_prev_r;

	// frequency divider on the muxed source
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mux_prev_r <= 1'b0;
			div_cnt_r <= '0;
		end else begin
			mux_prev_r <= mux_clk;
			if (mux_rise) begin
				div_cnt_r <= div_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sys_clk_r <= 1'b0;
		end else if (mode_div_r == mcsc_pkg::DIV_THRU) begin
			sys_clk_r <= mux_clk;
		end else begin
			sys_clk_r <= div_cnt_r[mode_div_r - 2'd1];
		end
	end

	// internal clock generator: instruction clock high one system period
	// out of every INSTR_DIV
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sys_prev_r <= 1'b0;
			instr_cnt_r <= 2'd0;
			instr_clk_r <= 1'b0;
		end else begin
			sys_prev_r <= sys_clk_r;
			if (sys_clk_r && !sys_prev_r) begin
				if (instr_cnt_r == 2'(mcsc_pkg::INSTR_DIV - 1)) begin
					instr_cnt_r <= 2'd0;
				end else begin
					instr_cnt_r <= instr_cnt_r + 2'd1;
				end
				instr_clk_r <= (instr_cnt_r == 2'd0);
			end
		end
	end

	assign sys_clk_o = sys_clk_r;
	assign instr_clk_o = instr_clk_r;

	chk_reset_ring: assert property (@(posedge clk_i)
		$past(sys_rst_i) && !sys_rst_i |-> mode_sel_r == mcsc_pkg::SRC_RING)
		else $error("ring oscillator not selected after reset");
	chk_reset_ceramic: assert property (@(posedge clk_i)
		$past(sys_rst_i) && !sys_rst_i |-> !main_rc_mode_o)
		else $error("main oscillator not ceramic after reset");
	chk_rc_select: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wr_en && paddr == mcsc_pkg::CMD_OFS && pwdata[0] |=> main_rc_mode_o)
		else $error("rc select did not enable rc mode");
	chk_rc_once: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		main_rc_mode_o |=> main_rc_mode_o)
		else $error("rc mode reverted without reset");
	chk_sub_port: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wr_en && paddr == mcsc_pkg::STOP_OFS && pwdata[2] &&
		mode_sel_r != mcsc_pkg::SRC_SUB && mux_cur != mcsc_pkg::SRC_SUB
		|=> !sub_osc_en_o && sub_clock_out_pin_o == port_r[1])
		else $error("sub-clock stop did not hand pins to port");
	chk_sub_pin_in: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		sub_osc_en_o |-> shared_port_bit_low_oe_n_o)
		else $error("sub-clock input pin driven in oscillator mode");
	chk_sel_not11: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		mode_sel_r != mcsc_pkg::SRC_NONE)
		else $error("select field holds 11");
	chk_sel_running: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!stop_r[mode_sel_r] && !stop_r[mux_cur])
		else $error("selected oscillator is stopped");
	chk_div_edge: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$changed(sys_clk_r) && $past(mode_div_r, 2) != mcsc_pkg::DIV_THRU &&
		$past(mode_div_r, 2) == mode_div_r && $past(mode_div_r) == mode_div_r
		|-> $past(mux_rise, 2))
		else $error("divided clock moved without a source edge");
	cov_rc: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(main_rc_mode_o));
	cov_div8: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		mode_div_r == mcsc_pkg::DIV_8 && $rose(sys_clk_r));
	cov_port: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(sub_osc_en_o));
endmodule
`default_nettype wire

// ### shared/mcsc_pkg.sv
// constants and types for the clock source control block
// Behaviour
// - system and instruction clocks come from selected source via mux, divider, generator
// - after reset the ring oscillator is the selected source
// - after reset the main oscillator runs in ceramic mode
// - rc select instruction turns ceramic off and rc mode on
// - rc select acts only once; later executions change nothing
// - sub-clock pins double as two port bits, chosen by sub-clock control bit
// - stop register bit 2 set stops sub-clock and hands pins to port
// - mode field picks through, divide by two, four or eight
// - select field picks ring, main or sub; pattern 11 never stored
// - selected oscillator cannot stop; stopped oscillator cannot be selected
`default_nettype none
package mcsc_pkg;
	// register byte offsets
	localparam logic [11:0] MODE_OFS = 12'h000;
	localparam logic [11:0] STOP_OFS = 12'h004;
	localparam logic [11:0] CMD_OFS = 12'h008;
	localparam logic [11:0] PORT_OFS = 12'h00C;
	localparam logic [11:0] STAT_OFS = 12'h010;
	// reset values
	localparam logic [3:0] MODE_RST = 4'hC;
	localparam logic [2:0] STOP_RST = 3'h0;
	localparam logic [3:0] PORT_RST = 4'h0;
	// field positions
	localparam int MODE_SEL_LSB = 0;
	localparam int MODE_DIV_LSB = 2;
	localparam int STOP_RING_BIT = 0;
	localparam int STOP_MAIN_BIT = 1;
	localparam int STOP_SUB_BIT = 2;
	localparam int CMD_RC_BIT = 0;
	localparam int CMD_PD_BIT = 1;
	localparam int CMD_DPD_BIT = 2;
	localparam int PORT_DIR_LSB = 2;
	localparam int PORT_PIN_LSB = 4;
	// instruction clock: system clocks per instruction clock period
	localparam int INSTR_DIV = 3;
	typedef enum logic [1:0] {
		SRC_RING = 2'b00,
		SRC_MAIN = 2'b01,
		SRC_SUB = 2'b10,
		SRC_NONE = 2'b11
	} mcsc_src_t;
	typedef enum logic [1:0] {
		DIV_THRU = 2'b00,
		DIV_2 = 2'b01,
		DIV_4 = 2'b10,
		DIV_8 = 2'b11
	} mcsc_div_t;
	typedef enum logic [1:0] {
		MUX_RUN = 2'b00,
		MUX_DRAIN = 2'b01,
		MUX_ARM = 2'b11
	} mcsc_mux_st_t;
endpackage
`default_nettype wire

// ### verification/mcsc_tb_top.sv
// self-checking bench for the clock source control block
`timescale 1ns/100ps
`default_nettype none
module mcsc_tb_top;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic ring_i = 1'b0;
	logic main_i = 1'b0;
	logic low_i = 1'b0;
	logic high_i = 1'b0;
	logic [31:0] prdata, q, pv, c;
	logic pready, pslverr, err, low_o, low_oe_n, high_o, high_oe_n;
	logic ring_en, main_en, rc_mode, sub_en, sys_clk, ins_clk, pd, dpd;
	int n_mismatch = 0;
	int n_compared = 0;
	int seed = 79;
	int m_sel = 0;
	int m_div = 3;
	int m_stop = 0;
	int p;
	always #5 clk_i = ~clk_i;
	// ring and main stand-ins at unequal rates so a wrong mux pick shows
	always begin
		repeat (3) @(posedge clk_i);
		ring_i <= ~ring_i;
	end
	always begin
		repeat (5) @(posedge clk_i);
		main_i <= ~main_i;
	end
	mcsc_top mcsc_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ring_osc_i(ring_i), .main_clock_in_pin_i(main_i),
		.shared_port_bit_low_i(low_i), .shared_port_bit_low_o(low_o),
		.shared_port_bit_low_oe_n_o(low_oe_n), .sub_clock_out_pin_i(high_i),
		.sub_clock_out_pin_o(high_o), .sub_clock_out_pin_oe_n_o(high_oe_n),
		.ring_osc_en_o(ring_en), .main_osc_en_o(main_en),
		.main_rc_mode_o(rc_mode), .sub_osc_en_o(sub_en), .sys_clk_o(sys_clk),
		.instr_clk_o(ins_clk), .power_down_o(pd), .deep_power_down_o(dpd));
	task automatic stop_test;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready !== 1'b1 && k < 100);
		if (k >= 100) begin
			n_mismatch++;
			stop_test();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk_i);
	endtask
	// period in clk cycles, skipping the first one after a change
	task automatic meas(input bit ins);
		int k;
		int e;
		logic prv;
		logic cur;
		k = 0;
		e = 0;
		p = 0;
		prv = 1'b1;
		while (e < 3 && k < 3000) begin
			@(posedge clk_i);
			cur = ins ? ins_clk : sys_clk;
			k++;
			if (e == 2)
				p++;
			if (cur === 1'b1 && prv === 1'b0)
				e++;
			prv = cur;
		end
		if (k >= 3000) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	task automatic wr_mode(input int sel, input int dv);
		apb(1'b1, mcsc_pkg::MODE_OFS, 32'(dv * 4 + sel));
		m_div = dv;
		if (sel != 3 && !m_stop[sel])
			m_sel = sel;
		apb(1'b0, mcsc_pkg::MODE_OFS, 32'h0);
		chk(q, 32'(m_div * 4 + m_sel));
	endtask
	// the model keeps the selected source running, as the block must
	task automatic wr_stop(input int d);
		apb(1'b1, mcsc_pkg::STOP_OFS, 32'(d));
		m_stop = d & ~(1 << m_sel);
		chk({ring_en, main_en, sub_en},
			{~m_stop[0], ~m_stop[1], ~m_stop[2]});
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(negedge clk_i);
		chk({ring_en, main_en, sub_en, rc_mode}, 4'hE);
		chk({high_o, high_oe_n}, 2'h2);
		// start-up code selects rc mode first; a repeat must change nothing
		repeat (2) begin
			apb(1'b1, mcsc_pkg::CMD_OFS, 32'h1);
			chk(rc_mode, 1'b1);
		end
		apb(1'b0, mcsc_pkg::MODE_OFS, 32'h0);
		chk(q, 32'(mcsc_pkg::MODE_RST));
		apb(1'b0, 12'h020, 32'h0);
		chk(err, 1'b1);
		chk(q, 32'h0);
		wr_stop(1);
		for (int dv = 0; dv < 4; dv++) begin
			wr_mode(0, dv);
			meas(1'b0);
			chk(p, 6 << dv);
			meas(1'b1);
			chk(p, 18 << dv);
		end
		wr_mode(3, 1);
		wr_mode(1, 0);
		meas(1'b0);
		chk(p, 10);
		apb(1'b0, mcsc_pkg::STAT_OFS, 32'h0);
		chk(q[2:0], 3'h1);
		wr_stop(1);
		wr_mode(0, 0);
		wr_stop(0);
		// sub-clock as source; its pin sits low, so the switch ends as soon as main goes low
		wr_mode(2, 0);
		repeat (10) @(posedge clk_i);
		apb(1'b0, mcsc_pkg::STAT_OFS, 32'h0);
		chk(q[2:0], 3'h2);
		wr_mode(1, 0);
		repeat (10) @(posedge clk_i);
		apb(1'b0, mcsc_pkg::STAT_OFS, 32'h0);
		chk(q[3], 1'b1);
		wr_stop(4);
		wr_mode(2, 0);
		repeat (4) begin
			pv = $random(seed);
			@(posedge clk_i);
			low_i <= pv[4];
			high_i <= pv[5];
			apb(1'b1, mcsc_pkg::PORT_OFS, {28'h0, pv[3:0]});
			chk({low_o, low_oe_n, high_o, high_oe_n},
				{pv[0], ~pv[2], pv[1], ~pv[3]});
			apb(1'b0, mcsc_pkg::PORT_OFS, 32'h0);
			chk(q[5:0], pv[5:0]);
		end
		// main stays an oscillator here, so power down is allowed
		for (int b = 1; b < 3; b++) begin
			apb(1'b1, mcsc_pkg::CMD_OFS, 32'(1 << b));
			// the pulse stands from the write edge up to the next edge
			c = (b == 1) ? pd : dpd;
			repeat (3) begin
				@(negedge clk_i);
				c = c + ((b == 1) ? pd : dpd);
			end
			chk(c, 1);
		end
		stop_test();
	end
endmodule
`default_nettype wire
